// >>> branch_flow_predictor.sv
// Branch flow predictor: target cache, static predictor, return stack, recovery and registers
// Contract
// - Target cache: 128 direct-mapped entries, virtual index, virtual target, two-bit direction.
// - Each entry carries a saturating two-bit counter driving the dynamic direction.
// - An entry is replaced only by another branch at the same index.
// - Direction history updates on every resolved execution of the cached branch.
// - Resolved branches, taken or not, are allocated after Execute.
// - A cache hit redirects the next fetch with no added cycle.
// - A control operation flushes all cached target entries; here a branch resolved in that same cycle stays valid.
// - Nothing is predicted while the global flow enable bit is clear.
// - Static direction comes from the offset sign: backward taken, forward conditional not.
// - The static predictor acts only when the dynamic one gave nothing.
// - A statically predicted taken branch redirects one cycle later.
// - Static prediction works in word and half states, not in byte-code state.
// - The target cache predicts branches and immediate link forms in all three states.
// - Branches resolve by the third execute stage; misprediction flushes and refetches.
// - Each prediction stores a recovery address: fall-through if taken, else target.
// - The condition field goes to the integer unit, which flushes and restarts on error.
// - The return stack is a three-entry circular buffer for unconditional returns only.
// - Resolved immediate or register link calls, predicted or not, push their Execute return address.
// - A predicted return fetches from the stack top and then pops it.
// - Immediate calls use the cache; register calls unpredicted; static: unconditional taken.
// - An empty return stack gives no return prediction.
// - Flow enable is bit 11 of the control register, cleared by reset.
// - Separate return, dynamic and static enables live in the auxiliary register.
// - The whole cache flushes on process or context id change and icache invalidate; here a branch resolved in that same cycle stays valid.
`timescale 1ns/10ps
`include "flow_predictor_consts.svh"

module branch_flow_predictor (
	input  wire logic                                 clk_in,
	input  wire logic                                 reset_n_in,
	input  wire logic [3:0]                           avs_address_in,
	input  wire logic                                 avs_read_in,
	input  wire logic                                 avs_write_in,
	input  wire logic [31:0]                          avs_writedata_in,
	output logic [31:0]                               avs_readdata_out,
	output logic                                      avs_waitrequest_out,
	input  wire flow_predictor_pkg::decode_info_type  decode_in,
	input  wire flow_predictor_pkg::resolve_info_type resolve_in,
	input  wire logic                                 mispredict_in,
	input  wire logic                                 process_id_change_in,
	input  wire logic                                 context_id_change_in,
	input  wire logic                                 icache_invalidate_in,
	output flow_predictor_pkg::redirect_type          redirect_out,
	output flow_predictor_pkg::recovery_type          recovery_out,
	output logic                                      prefetch_flush_out
);
	import flow_predictor_pkg::*;

	typedef struct packed {
		logic [31:0] system_control;
		logic [2:0]  aux_control;
		logic        bus_ack;
		logic        waitrequest;
		logic [31:0] readdata;
		logic [1:0]  rs_count;
		logic [1:0]  rs_top;
		logic [2:0][31:0] rs_entry;
		control_mode_type mode;
		logic [31:0] static_target;
		redirect_type redirect;
		recovery_type recovery;
		logic        flush;
		logic [15:0] hit_count;
	} state_type;

	state_type state_q;
	state_type state_d;

	// Cache arrays live outside the struct so they map to memory
	logic [`CACHE_ENTRIES-1:0]        cache_valid_q;
	logic [31:0]                      cache_tag_q    [`CACHE_ENTRIES];
	logic [31:0]                      cache_target_q [`CACHE_ENTRIES];
	logic [1:0]                       cache_ctr_q    [`CACHE_ENTRIES];

	function automatic logic [`CACHE_INDEX_BITS-1:0] cache_index(input logic [31:0] addr);
		cache_index = addr[`CACHE_INDEX_BITS+1:2];
	endfunction

	function automatic logic [1:0] saturate(input logic [1:0] ctr, input logic taken);
		if (taken) begin
			saturate = (ctr == 2'h3) ? 2'h3 : ctr + 2'h1;
		end else begin
			saturate = (ctr == 2'h0) ? 2'h0 : ctr - 2'h1;
		end
	endfunction

	function automatic logic [1:0] ring_step(input logic [1:0] ptr, input logic up);
		if (up) begin
			ring_step = (ptr == 2'h2) ? 2'h0 : ptr + 2'h1;
		end else begin
			ring_step = (ptr == 2'h0) ? 2'h2 : ptr - 2'h1;
		end
	endfunction

	logic [1:0] reset_sync_q;
	logic       reset_n;
	assign reset_n = reset_sync_q[1];

	logic                          flow_enable;
	logic                          aux_return;
	logic                          aux_dynamic;
	logic                          aux_static;
	logic [`CACHE_INDEX_BITS-1:0]  fetch_index;
	logic [`CACHE_INDEX_BITS-1:0]  resolve_index;
	logic                          cache_hit;
	logic                          dyn_taken;
	logic                          flush_cache;
	logic                          bus_access;
	logic                          return_ok;

	assign flow_enable   = state_q.system_control[`FLOW_ENABLE_BIT];
	assign aux_return    = flow_enable & state_q.aux_control[`AUX_RETURN_BIT];
	assign aux_dynamic   = flow_enable & state_q.aux_control[`AUX_DYNAMIC_BIT];
	assign aux_static    = flow_enable & state_q.aux_control[`AUX_STATIC_BIT];
	assign fetch_index   = cache_index(decode_in.addr);
	assign resolve_index = cache_index(resolve_in.addr);
	// Register calls never hit: cache_hit masks them out, though they are allocated
	assign cache_hit     = aux_dynamic & decode_in.is_branch & ~decode_in.is_call_reg
		& cache_valid_q[fetch_index] & (cache_tag_q[fetch_index] == decode_in.addr);
	assign dyn_taken     = cache_ctr_q[fetch_index][1];
	assign bus_access    = (avs_read_in | avs_write_in) & ~state_q.bus_ack;
	assign flush_cache   = process_id_change_in | context_id_change_in | icache_invalidate_in
		| (avs_write_in & state_q.bus_ack & (avs_address_in == `OFS_FLUSH_COMMAND)
		& avs_writedata_in[`FLUSH_ALL_BIT]);
	assign return_ok     = aux_return & decode_in.is_return & ~decode_in.conditional
		& (state_q.rs_count != 2'h0);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reset_sync_q <= 2'h0;
		end else begin
			reset_sync_q <= {reset_sync_q[0], 1'b1};
		end
	end

	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			state_q.system_control <= `SYSTEM_CONTROL_RESET;
			state_q.aux_control    <= `AUX_CONTROL_RESET;
			state_q.bus_ack        <= 1'b0;
			state_q.waitrequest    <= 1'b1;
			state_q.readdata       <= 32'h00000000;
			state_q.rs_count       <= 2'h0;
			state_q.rs_top         <= 2'h0;
			state_q.rs_entry       <= '0;
			state_q.mode           <= mode_idle;
			state_q.static_target  <= 32'h00000000;
			state_q.redirect       <= '0;
			state_q.recovery       <= '0;
			state_q.flush          <= 1'b0;
			state_q.hit_count      <= 16'h0000;
		end else begin
			state_q.system_control <= state_d.system_control;
			state_q.aux_control    <= state_d.aux_control;
			state_q.bus_ack        <= state_d.bus_ack;
			state_q.waitrequest    <= state_d.waitrequest;
			state_q.readdata       <= state_d.readdata;
			state_q.rs_count       <= state_d.rs_count;
			state_q.rs_top         <= state_d.rs_top;
			state_q.rs_entry       <= state_d.rs_entry;
			state_q.mode           <= state_d.mode;
			state_q.static_target  <= state_d.static_target;
			state_q.redirect       <= state_d.redirect;
			state_q.recovery       <= state_d.recovery;
			state_q.flush          <= state_d.flush;
			state_q.hit_count      <= state_d.hit_count;
		end
	end

	// Cache store; valid bits reset, data arrays need none
	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			cache_valid_q <= '0;
		end else begin
			if (flush_cache) begin
				cache_valid_q <= '0;
			end
			// Allocation after the clear: a branch resolved in the flush cycle survives
			if (resolve_in.valid) begin
				cache_valid_q[resolve_index] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (resolve_in.valid) begin
			if (cache_valid_q[resolve_index] & (cache_tag_q[resolve_index] == resolve_in.addr)) begin
				cache_ctr_q[resolve_index]    <= saturate(cache_ctr_q[resolve_index], resolve_in.taken);
				cache_target_q[resolve_index] <= resolve_in.target;
			end else begin
				// Only a same-index clash replaces an entry
				cache_tag_q[resolve_index]    <= resolve_in.addr;
				cache_target_q[resolve_index] <= resolve_in.target;
				cache_ctr_q[resolve_index]    <= resolve_in.taken ? `COUNTER_ALLOC_TAKEN
					: `COUNTER_ALLOC_NOT;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		state_d.bus_ack = bus_access;
		state_d.waitrequest = ~bus_access;
		state_d.redirect.valid = 1'b0;
		state_d.redirect.delayed = 1'b0;
		state_d.recovery.valid = 1'b0;
		state_d.flush = 1'b0;

		if (bus_access & avs_read_in) begin
			unique case (avs_address_in)
				`OFS_SYSTEM_CONTROL: state_d.readdata = state_q.system_control;
				`OFS_AUX_CONTROL:    state_d.readdata = {29'h00000000, state_q.aux_control};
				`OFS_STATUS:         state_d.readdata = {state_q.hit_count, 14'h0000, state_q.rs_count};
				default:             state_d.readdata = 32'h00000000;
			endcase
		end
		if (avs_write_in & state_q.bus_ack) begin
			if (avs_address_in == `OFS_SYSTEM_CONTROL) begin
				state_d.system_control = avs_writedata_in;
			end
			if (avs_address_in == `OFS_AUX_CONTROL) begin
				state_d.aux_control = avs_writedata_in[2:0];
			end
		end

		// Misprediction takes priority over any new prediction
		if (mispredict_in) begin
			state_d.flush = 1'b1;
			state_d.mode = mode_idle;
		end else begin
			unique case (state_q.mode)
				mode_idle: begin
					if (return_ok) begin
						state_d.redirect.valid = 1'b1;
						state_d.redirect.pc = state_q.rs_entry[state_q.rs_top];
						state_d.recovery.valid = 1'b1;
						state_d.recovery.recovery_addr = decode_in.fall_through;
						state_d.recovery.cond_field = decode_in.cond_field;
						state_d.rs_top = ring_step(state_q.rs_top, 1'b0);
						state_d.rs_count = state_q.rs_count - 2'h1;
					end else if (cache_hit) begin
						state_d.hit_count = state_q.hit_count + 16'h0001;
						state_d.redirect.valid = dyn_taken;
						state_d.redirect.pc = cache_target_q[fetch_index];
						state_d.recovery.valid = 1'b1;
						state_d.recovery.recovery_addr = dyn_taken ? decode_in.fall_through
							: cache_target_q[fetch_index];
						state_d.recovery.cond_field = decode_in.cond_field;
					end else if (aux_static & decode_in.is_branch & ~decode_in.is_call_reg
						& (decode_in.exec_state != state_bytecode)) begin
						state_d.recovery.valid = 1'b1;
						state_d.recovery.cond_field = decode_in.cond_field;
						if (decode_in.offset_msb | ~decode_in.conditional) begin
							state_d.static_target = decode_in.target;
							state_d.recovery.recovery_addr = decode_in.fall_through;
							state_d.mode = mode_static;
						end else begin
							state_d.recovery.recovery_addr = decode_in.target;
						end
					end
				end
				mode_static: begin
					state_d.redirect.valid = 1'b1;
					state_d.redirect.delayed = 1'b1;
					state_d.redirect.pc = state_q.static_target;
					state_d.mode = mode_idle;
				end
				default: state_d.mode = mode_idle;
			endcase
		end

		// Calls push their return address at Execute
		if (aux_return & resolve_in.valid & resolve_in.is_call) begin
			state_d.rs_top = ring_step(state_q.rs_top, 1'b1);
			state_d.rs_entry[ring_step(state_q.rs_top, 1'b1)] = resolve_in.return_addr;
			state_d.rs_count = (state_q.rs_count == 2'h3) ? 2'h3 : state_q.rs_count + 2'h1;
			if (return_ok & ~mispredict_in & state_q.mode == mode_idle) begin
				state_d.rs_top = state_q.rs_top;
				state_d.rs_entry[state_q.rs_top] = resolve_in.return_addr;
				state_d.rs_count = state_q.rs_count;
			end
		end
	end

	// Registered, so no path runs from the master's strobes back to it
	assign avs_waitrequest_out = state_q.waitrequest;
	assign avs_readdata_out    = state_q.readdata;
	assign redirect_out        = state_q.redirect;
	assign recovery_out        = state_q.recovery;
	assign prefetch_flush_out  = state_q.flush;

	chk_flow_off_quiet: assert property (@(posedge clk_in) disable iff (!reset_n)
		!state_q.system_control[`FLOW_ENABLE_BIT] && !$past(state_q.system_control[`FLOW_ENABLE_BIT])
		|-> !redirect_out.valid || redirect_out.delayed)
		else $error("prediction while flow disabled");
	chk_static_delay_one: assert property (@(posedge clk_in) disable iff (!reset_n)
		state_q.mode == mode_static && !mispredict_in |=> redirect_out.valid && redirect_out.delayed)
		else $error("static taken not redirected after one cycle");
	chk_mispredict_flush: assert property (@(posedge clk_in) disable iff (!reset_n)
		mispredict_in |=> prefetch_flush_out && !redirect_out.valid)
		else $error("misprediction did not flush");
	chk_stack_bound: assert property (@(posedge clk_in) disable iff (!reset_n)
		state_q.rs_count <= 2'h3 && state_q.rs_top <= 2'h2)
		else $error("return stack out of range");
	chk_empty_no_return: assert property (@(posedge clk_in) disable iff (!reset_n)
		state_q.rs_count == 2'h0 && decode_in.is_return && !decode_in.is_branch && state_q.mode == mode_idle
		|=> !redirect_out.valid)
		else $error("return predicted from empty stack");
	chk_pop_count: assert property (@(posedge clk_in) disable iff (!reset_n)
		return_ok && state_q.mode == mode_idle && !mispredict_in && !resolve_in.valid
		|=> state_q.rs_count == $past(state_q.rs_count) - 2'h1)
		else $error("pop did not drop one entry");
	chk_flush_clears: assert property (@(posedge clk_in) disable iff (!reset_n)
		(process_id_change_in || context_id_change_in || icache_invalidate_in) && !resolve_in.valid
		|=> cache_valid_q == '0)
		else $error("cache not flushed");
	chk_bytecode_static: assert property (@(posedge clk_in) disable iff (!reset_n)
		state_q.mode == mode_idle && !cache_hit && !return_ok && decode_in.exec_state == state_bytecode
		|=> state_q.mode == mode_idle)
		else $error("static prediction in byte-code state");
	chk_bus_answer: assert property (@(posedge clk_in) disable iff (!reset_n)
		avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("bus answer late");

endmodule

// >>> flow_predictor_consts.svh
// Constants for the branch flow predictor: offsets, fields, resets and sizes
`ifndef FLOW_PREDICTOR_CONSTS_SVH
`define FLOW_PREDICTOR_CONSTS_SVH

`define CACHE_ENTRIES       128
`define CACHE_INDEX_BITS    7
`define RETURN_STACK_DEPTH  3
`define PRED_RESOLVE_STAGES 3

`define OFS_SYSTEM_CONTROL  4'h0
`define OFS_AUX_CONTROL     4'h4
`define OFS_FLUSH_COMMAND   4'h8
`define OFS_STATUS          4'hC

`define FLOW_ENABLE_BIT     11
`define AUX_RETURN_BIT      0
`define AUX_DYNAMIC_BIT     1
`define AUX_STATIC_BIT      2
`define FLUSH_ALL_BIT       0

`define SYSTEM_CONTROL_RESET 32'h00000000
`define AUX_CONTROL_RESET    3'h7
`define COUNTER_ALLOC_TAKEN  2'h2
`define COUNTER_ALLOC_NOT    2'h1

`endif

// >>> flow_predictor_pkg.sv
// Types shared by the branch flow predictor
package flow_predictor_pkg;

	typedef enum logic [1:0] {
		state_word    = 2'h0,
		state_half    = 2'h1,
		state_bytecode = 2'h2
	} exec_state_type;

	typedef enum logic [3:0] {
		mode_idle   = 4'h1,
		mode_static = 4'h2,
		mode_flush  = 4'h4,
		mode_hold   = 4'h8
	} control_mode_type;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] target;
		logic [31:0] fall_through;
		logic        is_branch;
		logic        conditional;
		logic        offset_msb;
		logic        is_call_imm;
		logic        is_call_reg;
		logic        is_return;
		logic [3:0]  cond_field;
		exec_state_type exec_state;
	} decode_info_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        taken;
		logic [31:0] target;
		logic        is_call;
		logic [31:0] return_addr;
	} resolve_info_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] pc;
		logic        delayed;
	} redirect_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] recovery_addr;
		logic [3:0]  cond_field;
	} recovery_type;

endpackage

// >>> core_pipeline_model.sv
// Behavioural integer pipeline and prefetch side facing the flow predictor
`timescale 1ns/10ps
module core_pipeline_model (
	input  wire logic                         clk_in,
	input  wire logic                         prefetch_flush_in,
	output flow_predictor_pkg::decode_info_type  decode_out,
	output flow_predictor_pkg::resolve_info_type resolve_out,
	output logic                              mispredict_out
);
	import flow_predictor_pkg::*;

	int flushes;

	initial begin
		decode_out = '0;
		resolve_out = '0;
		mispredict_out = 1'b0;
		flushes = 0;
	end

	always @(posedge clk_in) begin
		if (prefetch_flush_in === 1'b1)
			flushes++;
	end

	// Idle lines show the inverse address and target with every flag clear, so a stale copy is never mistaken for a branch
	task automatic decode(input decode_info_type d);
		decode_info_type idle;
		idle = '0;
		idle.addr = ~d.addr;
		idle.target = ~d.target;
		decode_out <= d;
		@(posedge clk_in);
		decode_out <= idle;
	endtask

	task automatic resolve(input resolve_info_type r);
		resolve_info_type idle;
		idle = ~r;
		idle.valid = 1'b0;
		idle.is_call = 1'b0;
		resolve_out <= r;
		@(posedge clk_in);
		resolve_out <= idle;
	endtask

	// Condition field failed against the flags
	task automatic mispredict();
		mispredict_out <= 1'b1;
		@(posedge clk_in);
		mispredict_out <= 1'b0;
	endtask
endmodule

// >>> branch_flow_predictor_bench.sv
// Self-checking bench for the branch flow predictor
`timescale 1ns/10ps
module branch_flow_predictor_bench;
	import flow_predictor_pkg::*;

	typedef struct packed {
		logic [31:0] cyc;
		logic [31:0] val;
		logic        dly;
	} exp_type;

	logic             clk_in;
	logic             reset_n_in;
	logic [3:0]       avs_address_in;
	logic             avs_read_in;
	logic             avs_write_in;
	logic [31:0]      avs_writedata_in;
	logic [31:0]      avs_readdata_out;
	logic             avs_waitrequest_out;
	decode_info_type  decode;
	resolve_info_type resolve;
	logic             mispredict;
	logic             process_id_change_in;
	logic             context_id_change_in;
	logic             icache_invalidate_in;
	redirect_type     redirect;
	recovery_type     recovery;
	logic             prefetch_flush_out;
	logic [31:0]      cyc = 32'h0;
	logic [31:0]      rnd = 32'h4E;
	logic [31:0]      a, b, t, t2;
	logic [31:0]      q_rd[$];
	exp_type          q_redir[$], q_recov[$], q_flush[$];
	int               errors = 0;
	int               n_compared = 0;

	branch_flow_predictor u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .decode_in(decode),
		.resolve_in(resolve), .mispredict_in(mispredict), .process_id_change_in(process_id_change_in),
		.context_id_change_in(context_id_change_in), .icache_invalidate_in(icache_invalidate_in),
		.redirect_out(redirect), .recovery_out(recovery), .prefetch_flush_out(prefetch_flush_out));
	core_pipeline_model u_core (.clk_in(clk_in), .prefetch_flush_in(prefetch_flush_out), .decode_out(decode),
		.resolve_out(resolve), .mispredict_out(mispredict));

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	function automatic logic [31:0] addr(input logic [6:0] idx);
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return {rnd[31:9], idx, 2'b00};
	endfunction

	task automatic miss(input string m);
		errors++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task automatic final_report();
		if (q_rd.size() + q_redir.size() + q_recov.size() + q_flush.size() != 0)
			miss("expected output never seen");
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// Strict outputs with no note pending count as a mismatch
	task automatic chk(ref exp_type q[$], input logic v, input logic [31:0] val, input logic dly, input logic strict);
		while (q.size() != 0 && q[0].cyc < cyc) begin
			miss("expected output missing");
			void'(q.pop_front());
		end
		if (v === 1'b1) begin
			if (q.size() != 0 && q[0].cyc == cyc) begin
				n_compared++;
				if (q[0].val !== val || q[0].dly !== dly)
					miss("output value differs");
				void'(q.pop_front());
			end else if (strict)
				miss("unexpected output");
		end
	endtask

	always @(posedge clk_in) begin
		cyc <= cyc + 32'h1;
		chk(q_redir, redirect.valid, redirect.pc, redirect.delayed, 1'b1);
		chk(q_recov, recovery.valid, recovery.recovery_addr, 1'b0, 1'b1);
		chk(q_flush, prefetch_flush_out, 32'h0, 1'b0, 1'b1);
		if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
			n_compared++;
			if (q_rd.size() == 0 || avs_readdata_out !== q_rd[0])
				miss("read data differs");
			if (q_rd.size() != 0)
				void'(q_rd.pop_front());
		end
	end

	task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd, input logic [31:0] exp);
		avs_address_in <= ad;
		avs_writedata_in <= wd;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		if (!wr)
			q_rd.push_back(exp);
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		avs_address_in <= ~ad;
		avs_writedata_in <= ~wd;
		@(posedge clk_in);
	endtask

	// Kind: 0 nothing, 1 hit taken, 2 static taken, 3 predicted not taken, 4 register call, 5 immediate call
	task automatic dec(input logic [31:0] ad, tg, input logic cond, back, input exec_state_type st, input int kind);
		decode_info_type d;
		d = '0;
		d.addr = ad;
		d.target = tg;
		d.fall_through = ad + 32'h4;
		d.is_branch = 1'b1;
		d.conditional = cond;
		d.offset_msb = back;
		d.cond_field = 4'hA;
		d.exec_state = st;
		d.is_call_reg = (kind == 4);
		d.is_call_imm = (kind == 5);
		if (kind == 1)
			q_redir.push_back('{cyc + 32'h2, tg, 1'b0});
		if (kind == 2 || kind == 5)
			q_redir.push_back('{cyc + 32'h3, tg, 1'b1});
		if (kind != 0 && kind != 4)
			q_recov.push_back('{cyc + 32'h2, (kind == 3) ? tg : ad + 32'h4, 1'b0});
		u_core.decode(d);
		idle(4);
	endtask

	task automatic ret(input logic cond, input logic [31:0] ra, input logic hit);
		decode_info_type d;
		d = '0;
		d.addr = ra ^ 32'h00F0_0000;
		d.fall_through = d.addr + 32'h4;
		d.is_return = 1'b1;
		d.conditional = cond;
		if (hit) begin
			q_redir.push_back('{cyc + 32'h2, ra, 1'b0});
			q_recov.push_back('{cyc + 32'h2, d.fall_through, 1'b0});
		end
		u_core.decode(d);
		idle(4);
	endtask

	task automatic res(input logic [31:0] ad, tg, input logic tk, call, input logic [31:0] ra);
		u_core.resolve('{1'b1, ad, tk, tg, call, ra});
		idle(2);
	endtask

	initial begin
		reset_n_in = 1'b0;
		{avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
		{process_id_change_in, context_id_change_in, icache_invalidate_in} = 3'b000;
		idle(4);
		reset_n_in <= 1'b1;
		idle(5);
		bus(1'b0, 4'h0, 32'h0, 32'h0);
		bus(1'b0, 4'h4, 32'h0, 32'h7);
		bus(1'b0, 4'h8, 32'h0, 32'h0);
		bus(1'b0, 4'h2, 32'h0, 32'h0);
		bus(1'b0, 4'hC, 32'h0, 32'h0);
		a = addr(7'h10);
		t = addr(7'h33);
		dec(a, a - 32'h40, 1'b1, 1'b1, state_word, 0);
		bus(1'b1, 4'h0, 32'h800, 32'h0);
		bus(1'b0, 4'h0, 32'h0, 32'h800);
		dec(a, a - 32'h40, 1'b1, 1'b1, state_word, 2);
		dec(a, a - 32'h40, 1'b1, 1'b1, state_half, 2);
		dec(a, a - 32'h40, 1'b1, 1'b1, state_bytecode, 0);
		dec(a, a + 32'h40, 1'b1, 1'b0, state_word, 3);
		res(a, t, 1'b1, 1'b0, 32'h0);
		dec(a, t, 1'b0, 1'b0, state_bytecode, 1);
		repeat (3) res(a, t, 1'b0, 1'b0, 32'h0);
		dec(a, t, 1'b1, 1'b1, state_word, 3);
		res(a, t, 1'b1, 1'b0, 32'h0);
		dec(a, t, 1'b1, 1'b1, state_word, 3);
		res(a, t, 1'b1, 1'b0, 32'h0);
		dec(a, t, 1'b1, 1'b1, state_word, 1);
		dec(a, t, 1'b1, 1'b1, state_word, 4);
		dec(addr(7'h05), a, 1'b0, 1'b0, state_half, 5);
		bus(1'b1, 4'h4, 32'h5, 32'h0);
		dec(a, t, 1'b1, 1'b1, state_word, 2);
		bus(1'b1, 4'h4, 32'h3, 32'h0);
		dec(addr(7'h06), a, 1'b1, 1'b1, state_word, 0);
		bus(1'b1, 4'h4, 32'h7, 32'h0);
		b = a + 32'h200;
		t2 = addr(7'h22);
		res(b, t2, 1'b1, 1'b0, 32'h0);
		dec(a, t, 1'b1, 1'b1, state_word, 2);
		bus(1'b1, 4'h8, 32'h1, 32'h0);
		dec(b, t2, 1'b1, 1'b1, state_word, 2);
		for (int i = 0; i < 3; i++) begin
			res(b, t2, 1'b1, 1'b0, 32'h0);
			res(addr(7'h11), t, 1'b1, 1'b0, 32'h0);
			dec(b, t2, 1'b1, 1'b1, state_word, 1);
			process_id_change_in <= (i == 0);
			context_id_change_in <= (i == 1);
			icache_invalidate_in <= (i == 2);
			@(posedge clk_in);
			{process_id_change_in, context_id_change_in, icache_invalidate_in} <= 3'b000;
			idle(2);
			dec(b, t2, 1'b1, 1'b1, state_word, 2);
		end
		for (int i = 1; i <= 4; i++)
			res(addr(7'h40 + i[6:0]), t, 1'b1, 1'b1, 32'h1000 * i);
		bus(1'b0, 4'hC, 32'h0, 32'h00070003);
		ret(1'b1, 32'h4000, 1'b0);
		bus(1'b1, 4'h4, 32'h6, 32'h0);
		ret(1'b0, 32'h4000, 1'b0);
		bus(1'b1, 4'h4, 32'h7, 32'h0);
		ret(1'b0, 32'h4000, 1'b1);
		ret(1'b0, 32'h3000, 1'b1);
		ret(1'b0, 32'h2000, 1'b1);
		ret(1'b0, 32'h1000, 1'b0);
		res(b, t2, 1'b1, 1'b0, 32'h0);
		q_flush.push_back('{cyc + 32'h2, 32'h0, 1'b0});
		fork
			u_core.mispredict();
			dec(b, t2, 1'b1, 1'b0, state_word, 0);
		join
		idle(5);
		n_compared++;
		if (u_core.flushes != 1)
			miss("flush count differs");
		final_report();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#(20 * 4000);
		miss("watchdog expired");
		final_report();
	end
endmodule
